// File: rtl/pmbus_cmd_dev.sv
// command register set of the converter: storage, checks, flash copy, faults
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
module pmbus_cmd_dev #(
  parameter bit POS_LOGIC = 1'b0
) (
  input  wire logic                              core_clk,
  input  wire logic                              rst_b,
  pmbus_cmd_if.dev                               link,
  input  wire logic [pmbus_cmd_pkg::FAULT_W-1:0] fault_evt,
  input  wire logic                              running,
  input  wire logic                              on_pin,
  output logic                                   run_enable,
  output pmbus_cmd_pkg::reg_array_t              cfg,
  output logic [pmbus_cmd_pkg::FAULT_W-1:0]      fault_status,
  output logic                                   cml_err
);
  import pmbus_cmd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state and reset value

  typedef struct packed {
    reg_array_t           ram;
    reg_array_t           flash;
    logic [FAULT_W-1:0]   fault;
    logic                 cml;
    logic [15:0]          rdata;
    logic                 ack;
    logic                 nak;
    logic                 run;
  } dev_state_t;

  // on/off default follows the pin polarity of the build
  localparam logic [15:0] ONOFF_RST = POS_LOGIC ? ONOFF_POS_DEF
                                                : ONOFF_NEG_DEF;
  localparam reg_array_t RAM_RST = {RAM_DEF[NREG-1:2], ONOFF_RST,
                                    RAM_DEF[0]};

  dev_state_t  st_ff;
  dev_state_t  nxt_st;
  reg_desc_t   desc;
  reg_array_t  cand;
  logic [15:0] wval;
  logic [15:0] cmpval;
  logic        in_rng;
  logic        order_ok;
  logic        pin_on;
  logic        cmd_on;

  //////////////////////////////////////////////////////////////////////////
  // decode, range check and candidate array for a write

  always_comb begin
    desc   = reg_desc(link.cmd);
    wval   = link.wdata & desc.mask;
    // mantissa formats compare only the low 11 bits
    cmpval = desc.lin ? {5'h00, wval[10:0]} : wval;
    in_rng = desc.ok && (cmpval >= desc.lo) && (cmpval <= desc.hi) &&
             (!desc.lin || (wval[15:11] == desc.expo));
    for (int i = 0; i < NREG; i++) begin
      cand[i] = (desc.idx == 5'(i)) ? wval : st_ff.ram[i];
    end
  end

  // ordering between related limits, checked only when one of them moves
  always_comb begin
    order_ok = 1'b1;
    if ((desc.idx == IX_OV_F || desc.idx == IX_VSET) &&
        !(cand[IX_OV_F] > cand[IX_VSET])) begin
      order_ok = 1'b0;
    end
    if ((desc.idx == IX_OV_F || desc.idx == IX_OV_W) &&
        !(cand[IX_OV_F] > cand[IX_OV_W])) begin
      order_ok = 1'b0;
    end
    if ((desc.idx == IX_OC_F || desc.idx == IX_OC_W) &&
        !(cand[IX_OC_F] > cand[IX_OC_W])) begin
      order_ok = 1'b0;
    end
    if ((desc.idx == IX_OT_F || desc.idx == IX_OT_W) &&
        !(cand[IX_OT_F] > cand[IX_OT_W])) begin
      order_ok = 1'b0;
    end
    if ((desc.idx == IX_UV_ON || desc.idx == IX_UV_OFF) &&
        !({1'b0, cand[IX_UV_ON]} >=
          {1'b0, cand[IX_UV_OFF]} + {1'b0, UV_HYST})) begin
      order_ok = 1'b0;
    end
    if ((desc.idx == IX_PG_ON || desc.idx == IX_PG_OFF) &&
        !({1'b0, cand[IX_PG_ON]} >=
          {1'b0, cand[IX_PG_OFF]} + {1'b0, PG_HYST})) begin
      order_ok = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // start decision from the on/off source configuration

  always_comb begin
    // pin level after polarity, then each source may be ignored
    pin_on = st_ff.ram[IX_ONOFF][ONOFF_POL] ? on_pin : !on_pin;
    pin_on = pin_on || !st_ff.ram[IX_ONOFF][ONOFF_PIN_USE];
    cmd_on = st_ff.ram[IX_OUT_EN][OUT_EN_BIT] ||
             !st_ff.ram[IX_ONOFF][ONOFF_CMD_USE];
  end

  //////////////////////////////////////////////////////////////////////////
  // next state: reads, writes, send-byte commands, fault flags

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.nak = 1'b0;
    // new fault events always land, even beside a clear
    nxt_st.fault = st_ff.fault | fault_evt;
    nxt_st.run = !st_ff.ram[IX_ONOFF][ONOFF_PIN_NEED] ||
                 (pin_on && cmd_on);
    if (link.rd) begin
      if (link.cmd == CMD_FMT) begin
        nxt_st.rdata = {8'h00, FMT_VAL};
        nxt_st.ack   = 1'b1;
      end else if (desc.ok) begin
        nxt_st.rdata = st_ff.ram[desc.idx];
        nxt_st.ack   = 1'b1;
      end else begin
        nxt_st.nak = 1'b1;
      end
    end else if (link.wr) begin
      if (in_rng && order_ok) begin
        nxt_st.ram[desc.idx] = wval;
        nxt_st.ack           = 1'b1;
      end else begin
        nxt_st.nak = 1'b1;
      end
    end else if (link.send) begin
      case (link.cmd)
        CMD_CLR: begin
          nxt_st.fault = fault_evt;
          nxt_st.cml   = 1'b0;
          nxt_st.ack   = 1'b1;
        end
        CMD_STORE: begin
          nxt_st.flash = st_ff.ram;
          nxt_st.ack   = 1'b1;
        end
        CMD_RESTORE: begin
          if (running) begin
            nxt_st.nak = 1'b1;
          end else begin
            nxt_st.ram = st_ff.flash;
            nxt_st.ack = 1'b1;
          end
        end
        default: begin
          nxt_st.nak = 1'b1;
        end
      endcase
    end
    // a refused access raises the communication error flag
    if (nxt_st.nak) begin
      nxt_st.cml = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; flash starts out holding the reset values

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{ram: RAM_RST, flash: RAM_RST, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.rdata   = st_ff.rdata;
  assign link.ack     = st_ff.ack;
  assign link.nak     = st_ff.nak;
  assign cfg          = st_ff.ram;
  assign fault_status = st_ff.fault;
  assign cml_err      = st_ff.cml;
  assign run_enable   = st_ff.run;

endmodule : pmbus_cmd_dev

// File: rtl/pmbus_cmd_host.sv
// host controller end: forwards software accesses onto the command link
`timescale 1ns/1ns
module pmbus_cmd_host (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  pmbus_cmd_if.host        link,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        running
);
  import pmbus_cmd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0] stat;    // bit0 refused by device, bit1 restore blocked
    logic       own_rd;  // read in the previous cycle hit the local status register
  } host_state_t;

  host_state_t st_ff;
  host_state_t nxt_st;
  logic        own;
  logic        is_send;
  logic        block;

  //////////////////////////////////////////////////////////////////////////
  // decode and forwarding

  always_comb begin
    own     = (addr == HOST_STAT_ADDR);
    is_send = (addr == CMD_CLR) || (addr == CMD_STORE) ||
              (addr == CMD_RESTORE);
    // restore is held back while the converter runs
    block   = wr && (addr == CMD_RESTORE) && running;
  end

  assign link.cmd   = addr;
  assign link.wdata = wdata;
  assign link.wr    = wr && !own && !is_send;
  assign link.send  = wr && is_send && !block;
  assign link.rd    = rd && !own;

  //////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, new events win

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.own_rd = rd && own;
    if (wr && own) begin
      nxt_st.stat = st_ff.stat & ~wdata[1:0];
    end
    nxt_st.stat[0] = nxt_st.stat[0] || link.nak;
    nxt_st.stat[1] = nxt_st.stat[1] || block;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.own_rd ? {14'h0000, st_ff.stat} : link.rdata;

endmodule : pmbus_cmd_host

// File: rtl/pmbus_cmd_if.sv
// command link between the host controller and the command register set
`timescale 1ns/1ns
interface pmbus_cmd_if;
  logic [7:0]  cmd;    // command code
  logic [15:0] wdata;  // write word, bytes in the low half
  logic        wr;     // write strobe
  logic        rd;     // read strobe
  logic        send;   // send-byte strobe
  logic [15:0] rdata;  // read answer, stands until the next accepted read
  logic        ack;    // accepted, one cycle after the strobe
  logic        nak;    // refused, one cycle after the strobe

  modport dev (input cmd, wdata, wr, rd, send, output rdata, ack, nak);
  modport host (output cmd, wdata, wr, rd, send, input rdata, ack, nak);
endinterface : pmbus_cmd_if

// File: rtl/pmbus_cmd_pkg.sv
// shared codes, limits, defaults and types of the power command register set
//
// Contract
// - output enable byte, default 0x80
// - on/off source byte, 0x1d or 0x1f
// - clear-faults command clears set fault bits
// - store-all copies working values into flash
// - restore-all reloads working values from flash
// - host never restores while converter runs
// - output format byte always reads 0x14
// - setpoint word, exponent -12, 9.6..13.2 V
// - frequency word, exponent -2, 120..140 kHz
// - lockout turn-on word, default 34 V
// - lockout turn-off word, exponent -3, 32 V
// - turn-on threshold exceeds turn-off by 2 V
// - overvoltage fault above setpoint and warning; checked on writes only, fault and warning both reset to 0xf000
// - overvoltage action byte, default 0xb8
// - overcurrent fault word, above warning limit
// - overcurrent action byte, default 0xf8
// - overcurrent warning word, 10..45 A
// - overtemperature fault above warning, exponent -2
// - overtemperature action byte, default 0xb8
// - input overvoltage word, 48..110 V
// - good-output levels, assert 1.6 V above negate
// - turn-on delay word, exponent -1, 5..500 ms
package pmbus_cmd_pkg;

  // command codes
  localparam logic [7:0] CMD_OUT_EN  = 8'h01, CMD_ONOFF  = 8'h02;
  localparam logic [7:0] CMD_CLR     = 8'h03, CMD_STORE  = 8'h11;
  localparam logic [7:0] CMD_RESTORE = 8'h12, CMD_FMT    = 8'h20;
  localparam logic [7:0] CMD_VSET    = 8'h21, CMD_FSW    = 8'h33;
  localparam logic [7:0] CMD_UV_ON   = 8'h35, CMD_UV_OFF = 8'h36;
  localparam logic [7:0] CMD_OV_F    = 8'h40, CMD_OV_ACT = 8'h41;
  localparam logic [7:0] CMD_OV_W    = 8'h42, CMD_OC_F   = 8'h46;
  localparam logic [7:0] CMD_OC_ACT  = 8'h47, CMD_OC_W   = 8'h4a;
  localparam logic [7:0] CMD_OT_F    = 8'h4f, CMD_OT_ACT = 8'h50;
  localparam logic [7:0] CMD_OT_W    = 8'h51, CMD_VIN_OV = 8'h55;
  localparam logic [7:0] CMD_PG_ON   = 8'h5e, CMD_PG_OFF = 8'h5f;
  localparam logic [7:0] CMD_TON     = 8'h60;
  // host-side status register, outside the command space
  localparam logic [7:0] HOST_STAT_ADDR = 8'hf0;

  // storage slots of the working and flash arrays
  localparam int unsigned NREG = 19;
  localparam logic [4:0] IX_OUT_EN = 5'h00, IX_ONOFF  = 5'h01;
  localparam logic [4:0] IX_VSET   = 5'h02, IX_FSW    = 5'h03;
  localparam logic [4:0] IX_UV_ON  = 5'h04, IX_UV_OFF = 5'h05;
  localparam logic [4:0] IX_OV_F   = 5'h06, IX_OV_ACT = 5'h07;
  localparam logic [4:0] IX_OV_W   = 5'h08, IX_OC_F   = 5'h09;
  localparam logic [4:0] IX_OC_ACT = 5'h0a, IX_OC_W   = 5'h0b;
  localparam logic [4:0] IX_OT_F   = 5'h0c, IX_OT_ACT = 5'h0d;
  localparam logic [4:0] IX_OT_W   = 5'h0e, IX_VIN_OV = 5'h0f;
  localparam logic [4:0] IX_PG_ON  = 5'h10, IX_PG_OFF = 5'h11;
  localparam logic [4:0] IX_TON    = 5'h12;

  // field positions and masks
  localparam int unsigned OUT_EN_BIT = 7;
  localparam int unsigned ONOFF_PIN_NEED = 4, ONOFF_CMD_USE = 3;
  localparam int unsigned ONOFF_PIN_USE = 2, ONOFF_POL = 1;
  localparam logic [15:0] MASK_OUT_EN = 16'h0080, MASK_ONOFF = 16'h001f;
  localparam logic [15:0] MASK_BYTE = 16'h00ff, MASK_WORD = 16'hffff;
  localparam logic [7:0]  FMT_VAL = 8'h14;
  // five-bit exponent fields of the 11-bit mantissa formats
  localparam logic [4:0] EXP_M1 = 5'h1f, EXP_M2 = 5'h1e;
  localparam logic [4:0] EXP_M3 = 5'h1d, EXP_M4 = 5'h1c;

  // reset values
  localparam logic [15:0] OUT_EN_DEF = 16'h0080;
  localparam logic [15:0] ONOFF_NEG_DEF = 16'h001d, ONOFF_POS_DEF = 16'h001f;
  localparam logic [15:0] ACT_OV_DEF = 16'h00b8, ACT_OC_DEF = 16'h00f8;
  localparam logic [15:0] ACT_OT_DEF = 16'h00b8;
  localparam logic [15:0] VSET_DEF = 16'hc000, FSW_DEF = 16'hf208;
  localparam logic [15:0] UV_ON_DEF = 16'he910, UV_OFF_DEF = 16'he900;
  localparam logic [15:0] OV_F_DEF = 16'hf000, OV_W_DEF = 16'hf000;
  localparam logic [15:0] OC_F_DEF = 16'he360, OC_W_DEF = 16'he2d0;
  localparam logic [15:0] OT_F_DEF = 16'hf1f4, OT_W_DEF = 16'hf1cc;
  localparam logic [15:0] VIN_OV_DEF = 16'heb70, TON_DEF = 16'hf80e;
  localparam logic [15:0] PG_ON_DEF = 16'hb000, PG_OFF_DEF = 16'h9000;

  // limits: whole word for output-voltage words, mantissa otherwise
  localparam logic [15:0] VSET_LO = 16'h999a, VSET_HI = 16'hd333;
  localparam logic [15:0] FSW_LO = 16'h01e0, FSW_HI = 16'h0230;
  localparam logic [15:0] UV_LO = 16'h0100, UV_HI = 16'h0170;
  localparam logic [15:0] OV_LO = 16'hb000, OV_HI = 16'hffff;
  localparam logic [15:0] OC_F_LO = 16'h0140, OC_F_HI = 16'h03c0;
  localparam logic [15:0] OC_W_LO = 16'h00a0, OC_W_HI = 16'h02d0;
  localparam logic [15:0] OT_F_LO = 16'h0064, OT_F_HI = 16'h0230;
  localparam logic [15:0] OT_W_LO = 16'h0064, OT_W_HI = 16'h01f4;
  localparam logic [15:0] VIN_OV_LO = 16'h0180, VIN_OV_HI = 16'h0370;
  localparam logic [15:0] PG_LO = 16'h819a, PG_HI = 16'hd333;
  localparam logic [15:0] TON_LO = 16'h000a, TON_HI = 16'h03e8;
  localparam logic [15:0] UV_HYST = 16'h0010, PG_HYST = 16'h199a;

  localparam int unsigned FAULT_W = 8;

  typedef logic [NREG-1:0][15:0] reg_array_t;

  // working values after reset, on/off slot holding the negative build
  localparam reg_array_t RAM_DEF = {TON_DEF, PG_OFF_DEF, PG_ON_DEF,
    VIN_OV_DEF, OT_W_DEF, ACT_OT_DEF, OT_F_DEF, OC_W_DEF, ACT_OC_DEF,
    OC_F_DEF, OV_W_DEF, ACT_OV_DEF, OV_F_DEF, UV_OFF_DEF, UV_ON_DEF,
    FSW_DEF, VSET_DEF, ONOFF_NEG_DEF, OUT_EN_DEF};

  typedef struct packed {
    logic        ok;
    logic [4:0]  idx;
    logic [15:0] mask;
    logic        lin;
    logic [4:0]  expo;
    logic [15:0] lo;
    logic [15:0] hi;
  } reg_desc_t;

  // decode of a stored command: slot, mask, format and limits
  function automatic reg_desc_t reg_desc(input logic [7:0] code);
    reg_desc_t d;
    d = '0;
    case (code)
      CMD_OUT_EN: d = '{1'b1, IX_OUT_EN, MASK_OUT_EN, 1'b0, 5'h00, '0, OV_HI};
      CMD_ONOFF:  d = '{1'b1, IX_ONOFF, MASK_ONOFF, 1'b0, 5'h00, '0, OV_HI};
      CMD_VSET:   d = '{1'b1, IX_VSET, MASK_WORD, 1'b0, 5'h00, VSET_LO,
                        VSET_HI};
      CMD_FSW:    d = '{1'b1, IX_FSW, MASK_WORD, 1'b1, EXP_M2, FSW_LO, FSW_HI};
      CMD_UV_ON:  d = '{1'b1, IX_UV_ON, MASK_WORD, 1'b1, EXP_M3, UV_LO, UV_HI};
      CMD_UV_OFF: d = '{1'b1, IX_UV_OFF, MASK_WORD, 1'b1, EXP_M3, UV_LO,
                        UV_HI};
      CMD_OV_F:   d = '{1'b1, IX_OV_F, MASK_WORD, 1'b0, 5'h00, OV_LO, OV_HI};
      CMD_OV_ACT: d = '{1'b1, IX_OV_ACT, MASK_BYTE, 1'b0, 5'h00, '0, OV_HI};
      CMD_OV_W:   d = '{1'b1, IX_OV_W, MASK_WORD, 1'b0, 5'h00, OV_LO, OV_HI};
      CMD_OC_F:   d = '{1'b1, IX_OC_F, MASK_WORD, 1'b1, EXP_M4, OC_F_LO,
                        OC_F_HI};
      CMD_OC_ACT: d = '{1'b1, IX_OC_ACT, MASK_BYTE, 1'b0, 5'h00, '0, OV_HI};
      CMD_OC_W:   d = '{1'b1, IX_OC_W, MASK_WORD, 1'b1, EXP_M4, OC_W_LO,
                        OC_W_HI};
      CMD_OT_F:   d = '{1'b1, IX_OT_F, MASK_WORD, 1'b1, EXP_M2, OT_F_LO,
                        OT_F_HI};
      CMD_OT_ACT: d = '{1'b1, IX_OT_ACT, MASK_BYTE, 1'b0, 5'h00, '0, OV_HI};
      CMD_OT_W:   d = '{1'b1, IX_OT_W, MASK_WORD, 1'b1, EXP_M2, OT_W_LO,
                        OT_W_HI};
      CMD_VIN_OV: d = '{1'b1, IX_VIN_OV, MASK_WORD, 1'b1, EXP_M3, VIN_OV_LO,
                        VIN_OV_HI};
      CMD_PG_ON:  d = '{1'b1, IX_PG_ON, MASK_WORD, 1'b0, 5'h00, PG_LO, PG_HI};
      CMD_PG_OFF: d = '{1'b1, IX_PG_OFF, MASK_WORD, 1'b0, 5'h00, PG_LO, PG_HI};
      CMD_TON:    d = '{1'b1, IX_TON, MASK_WORD, 1'b1, EXP_M1, TON_LO, TON_HI};
      default:    d = '0;
    endcase
    return d;
  endfunction : reg_desc

endpackage : pmbus_cmd_pkg

// File: verif/pmbus_cmd_assertions.sv
// checker of the command link between host end and register set
`timescale 1ns/1ns
module pmbus_cmd_assertions (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  cmd,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        send,
  input wire logic [15:0] rdata,
  input wire logic        ack,
  input wire logic        nak
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////
  // link answers
  property p_answer;
    (wr || rd || send) |=> (ack != nak);
  endproperty
  a_answer: assert property (p_answer)
    else $error("strobe without single answer");
  property p_no_echo;
    (ack || nak) |-> $past(wr || rd || send);
  endproperty
  a_no_echo: assert property (p_no_echo)
    else $error("answer without strobe");
  property p_fmt;
    (rd && cmd == 8'h20) |=> (ack && rdata == 16'h0014);
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("format byte read wrong");
  property p_fmt_ro;
    (wr && cmd == 8'h20) |=> nak;
  endproperty
  a_fmt_ro: assert property (p_fmt_ro)
    else $error("format byte write accepted");
  property p_op_rsv;
    (rd && cmd == 8'h01) |=> (rdata[6:0] == 7'h00);
  endproperty
  a_op_rsv: assert property (p_op_rsv)
    else $error("enable byte reserved bits set");
  property p_cfg_rsv;
    (rd && cmd == 8'h02) |=> (rdata[15:5] == 11'h000);
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv)
    else $error("source byte reserved bits set");
  property p_vset;
    (wr && cmd == 8'h21 && (wdata < 16'h999a || wdata > 16'hd333)) |=> nak;
  endproperty
  a_vset: assert property (p_vset)
    else $error("setpoint out of range accepted");
  property p_ton_exp;
    (wr && cmd == 8'h60 && wdata[15:11] != 5'h1f) |=> nak;
  endproperty
  a_ton_exp: assert property (p_ton_exp)
    else $error("delay word exponent accepted");
  property p_clear;
    (send && cmd == 8'h03) |=> ack;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear command refused");
  // main scenarios seen
  c_read: cover property (rd ##1 ack);
  c_nak: cover property (wr ##1 nak);
  c_send: cover property (send ##1 ack);
endmodule : pmbus_cmd_assertions

// File: verif/testbench.sv
// self-checking bench for the host end and register set pair
`timescale 1ns/1ns
module testbench;
  import pmbus_cmd_pkg::*;
  logic               core_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [15:0]        wdata = 16'h0000;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic               running = 1'b0;
  logic               on_pin = 1'b0;
  logic [FAULT_W-1:0] fault_evt = '0;
  logic [15:0]        rdata;
  logic               run_enable;
  reg_array_t         cfg;
  logic [FAULT_W-1:0] fault_status;
  logic               cml_err;
  int                 fail_count = 0;
  int                 samples_checked = 0;
  logic [15:0]        mdl [256];
  logic [15:0]        snap [256];
  // reset values as {code, value}
  localparam logic [23:0] DEF [21] = '{24'h010080, 24'h02001d, 24'h200014,
    24'h21c000, 24'h33f208, 24'h35e910, 24'h36e900, 24'h40f000, 24'h4100b8,
    24'h42f000, 24'h46e360, 24'h4700f8, 24'h4ae2d0, 24'h4ff1f4, 24'h5000b8,
    24'h51f1cc, 24'h55eb70, 24'h5eb000, 24'h5f9000, 24'h60f80e, 24'h200014};
  // writes as {code, written, stored, accepted}
  localparam logic [43:0] RNG [33] = '{
    44'h21999a999a1, 44'h21999900000, 44'h21d33400000,
    44'h33f1e0f1e01, 44'h33f23100000, 44'h33e1e000000,
    44'h35e970e9701, 44'h35e97100000,
    44'h36e950e9501, 44'h36e96100000,
    44'h4ae2d100000, 44'h4ae0a0e0a01,
    44'h46e140e1401, 44'h46e13f00000,
    44'h4ff230f2301, 44'h4ff23100000, 44'h51f1f4f1f41,
    44'h51f1f500000, 44'h4ff1f400000,
    44'h42b000b0001, 44'h40b00000000, 44'h40b001b0011,
    44'h55e980e9801, 44'h55eb7100000,
    44'h5f966700000, 44'h5f966696661,
    44'h60f80af80a1, 44'h60f80900000, 44'h60e80a00000,
    44'h20000000000,
    44'h0100ff00801, 44'h0200ff001f1,
    44'h4100aa00aa1};

  pmbus_cmd_if pmbus_cmd_if_i ();
  pmbus_cmd_host pmbus_cmd_host_i (.core_clk(core_clk), .rst_b(rst_b),
    .link(pmbus_cmd_if_i.host), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .running(running));
  pmbus_cmd_dev pmbus_cmd_dev_i (.core_clk(core_clk), .rst_b(rst_b),
    .link(pmbus_cmd_if_i.dev), .fault_evt(fault_evt), .running(running),
    .on_pin(on_pin), .run_enable(run_enable), .cfg(cfg),
    .fault_status(fault_status), .cml_err(cml_err));
  pmbus_cmd_assertions pmbus_cmd_assertions_i (.core_clk(core_clk),
    .rst_b(rst_b), .cmd(pmbus_cmd_if_i.cmd), .wdata(pmbus_cmd_if_i.wdata),
    .wr(pmbus_cmd_if_i.wr), .rd(pmbus_cmd_if_i.rd),
    .send(pmbus_cmd_if_i.send), .rdata(pmbus_cmd_if_i.rdata),
    .ack(pmbus_cmd_if_i.ack), .nak(pmbus_cmd_if_i.nak));
  ////////////////////////////////////////////////////////////////////////
  // clock generator
  always #50 core_clk = ~core_clk;
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // one software access; resp is {nak, ack} expected on the link
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [1:0] resp);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge core_clk);
    check({14'h0, pmbus_cmd_if_i.nak, pmbus_cmd_if_i.ack},
          {14'h0, resp});
  endtask : acc
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    foreach (DEF[i]) begin
      acc(1'b0, DEF[i][23:16], 16'h0, 2'b01);
      check(rdata, DEF[i][15:0]);
      mdl[DEF[i][23:16]] = DEF[i][15:0];
    end
    acc(1'b0, 8'h11, 16'h0, 2'b10);
    acc(1'b1, 8'h7f, 16'h1234, 2'b10);
    $display("defaults test done");
  endtask : t_defaults
  task automatic t_onoff;
    @(posedge core_clk);
    on_pin <= 1'b1;
    repeat (3) @(negedge core_clk);
    check({15'h0, run_enable}, 16'h0000);
    @(posedge core_clk);
    on_pin <= 1'b0;
    repeat (3) @(negedge core_clk);
    check({15'h0, run_enable}, 16'h0001);
    acc(1'b1, 8'h01, 16'h0000, 2'b01);
    repeat (2) @(negedge core_clk);
    check({15'h0, run_enable}, 16'h0000);
    acc(1'b1, 8'h01, 16'h0080, 2'b01);
    $display("on/off test done");
  endtask : t_onoff
  task automatic t_limits;
    logic [7:0] c;
    foreach (RNG[i]) begin
      c = RNG[i][43:36];
      acc(1'b1, c, RNG[i][35:20], RNG[i][0] ? 2'b01 : 2'b10);
      if (RNG[i][0]) mdl[c] = RNG[i][19:4];
      acc(1'b0, c, 16'h0, 2'b01);
      check(rdata, mdl[c]);
    end
    check({15'h0, cml_err}, 16'h0001);
    $display("limits test done");
  endtask : t_limits
  task automatic t_flash;
    acc(1'b1, 8'h11, 16'h0, 2'b01);
    snap = mdl;
    // setpoints stay below the lowered overvoltage fault level
    acc(1'b1, 8'h21, 16'ha000, 2'b01);
    acc(1'b1, 8'h12, 16'h0, 2'b01);
    acc(1'b0, 8'h21, 16'h0, 2'b01);
    check(rdata, snap[8'h21]);
    @(posedge core_clk);
    running <= 1'b1;
    acc(1'b1, 8'h21, 16'ha800, 2'b01);
    acc(1'b1, 8'h12, 16'h0, 2'b00);
    acc(1'b0, 8'h21, 16'h0, 2'b01);
    check(rdata, 16'ha800);
    check(cfg[IX_VSET], 16'ha800);
    acc(1'b0, 8'hf0, 16'h0, 2'b00);
    check({15'h0, rdata[1]}, 16'h0001);
    acc(1'b1, 8'hf0, 16'h0003, 2'b00);
    acc(1'b0, 8'hf0, 16'h0, 2'b00);
    check(rdata, 16'h0000);
    @(posedge core_clk);
    running <= 1'b0;
    $display("flash test done");
  endtask : t_flash
  task automatic t_faults;
    @(posedge core_clk);
    fault_evt <= 8'h5a;
    @(posedge core_clk);
    fault_evt <= 8'h00;
    @(negedge core_clk);
    check({8'h0, fault_status}, 16'h005a);
    acc(1'b1, 8'h03, 16'h0, 2'b01);
    check({8'h0, fault_status}, 16'h0000);
    check({15'h0, cml_err}, 16'h0000);
    $display("faults test done");
  endtask : t_faults
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_defaults();
    t_onoff();
    t_limits();
    t_flash();
    t_faults();
    print_verdict();
  end
  // watchdog, well beyond the few hundred cycles the tests take
  initial begin
    #(5000 * 100);
    fail_count++;
    print_verdict();
  end
endmodule : testbench
